/* File: common/indicate_pkg.sv */
// Purpose: Shared constants and types for the indicate encoder and its FIFO.
// Assumes: One byte clock domain; symbols arrive already decoded as 4-bit nibbles.
// Notes: Control symbol codes and line-state codes are fixed here for the whole design.
`default_nettype none

package indicate_pkg;

  // ----------------------------------------------------------------------
  // Widths and buffering.
  // ----------------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int LS_W = 3;
  localparam int FIFO_W = BYTE_W + 1;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] FIFO_ROOM_LIMIT = 4'h6;

  // ----------------------------------------------------------------------
  // Control symbol codes carried on the data nibble when the control bit is set.
  // ----------------------------------------------------------------------
  localparam logic [NIB_W-1:0] SYM_QUIET = 4'h0;
  localparam logic [NIB_W-1:0] SYM_HALT = 4'h1;
  localparam logic [NIB_W-1:0] SYM_IDLE = 4'h2;
  localparam logic [NIB_W-1:0] SYM_J = 4'h3;
  localparam logic [NIB_W-1:0] SYM_K = 4'h4;
  localparam logic [NIB_W-1:0] SYM_T = 4'h5;
  localparam logic [NIB_W-1:0] SYM_R = 4'h6;
  localparam logic [NIB_W-1:0] SYM_S = 4'h7;
  localparam logic [NIB_W-1:0] SYM_VIOL = 4'h8;

  // ----------------------------------------------------------------------
  // Line-state codes used on the detector input and in the receive state field.
  // ----------------------------------------------------------------------
  localparam logic [LS_W-1:0] LSC_QUIET = 3'h0;
  localparam logic [LS_W-1:0] LSC_HALT = 3'h1;
  localparam logic [LS_W-1:0] LSC_MASTER = 3'h2;
  localparam logic [LS_W-1:0] LSC_IDLE = 3'h3;
  localparam logic [LS_W-1:0] LSC_NOISE = 3'h4;
  localparam logic [LS_W-1:0] LSC_ACTIVE = 3'h5;
  localparam logic [LS_W-1:0] LSC_UNKNOWN = 3'h6;

  // ----------------------------------------------------------------------
  // Indicate code layout.
  // ----------------------------------------------------------------------
  localparam int KNOWN_BIT = 3;
  localparam logic [NIB_W-1:0] ZERO_NIB = 4'h0;
  localparam logic [NIB_W-1:0] LS_MARK = 4'h0;
  localparam logic [NIB_W-1:0] PHY_INVALID_FIELD = 4'h3;
  localparam logic [NIB_W-1:0] IDLE_KNOWN_FIELD = 4'hB;
  localparam logic [NIB_W-1:0] IDLE_UNKNOWN_FIELD = 4'h3;

  typedef enum logic [2:0] {
    ACTIVE_LINE_STATE,
    IDLE_LINE_STATE,
    HALT_LINE_STATE,
    QUIET_LINE_STATE,
    MASTER_LINE_STATE,
    NOISE_LINE_STATE,
    UNKNOWN_LINE_STATE
  } line_state_t;

endpackage : indicate_pkg

`default_nettype wire

/* File: core/indicate_fifo.sv */
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes: The fill count is exported so the producer can stall ahead of time.
`default_nettype none

module indicate_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int CW = 4
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // ----------------------------------------------------------------------
  // Pointer and count update.
  // ----------------------------------------------------------------------
  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule : indicate_fifo

`default_nettype wire

/* File: core/phy_mac_indicate_encoder.sv */
// Purpose: Turns decoded receive symbol pairs into byte-wide indicate codes for the MAC.
// Assumes: Symbol pairs and line-state reports come from logic on CLK.
// Notes: An 8-word FIFO sits between the encoder and the indicate output registers.
`default_nettype none

// Summary of operation
// - Every indicate byte carries data, control or line state.
// - Active state forwards every data and control pair.
// - Mixed pair zeroes data nibble, flags byte control.
// - Starting delimiter pair switches line state to active.
// - Idle state with non-idle symbol sends unknown idle.
// - Idle state with two idles sends known idle.
// - Known flag in bit three, state below it.
// - Invalid condition codes 0011, known idle codes 1011.
// - Known flag set only when symbols match state.
// - Other states send known code on matching symbols.
// - Other states send unknown code on mismatching symbols.
// - Invalid condition in halt, quiet, master, noise, some unknown.
module phy_mac_indicate_encoder
  import indicate_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SYM_VALID,
  output logic SYM_READY,
  input wire logic SYM1_CTRL,
  input wire logic [NIB_W-1:0] SYM1_DATA,
  input wire logic SYM2_CTRL,
  input wire logic [NIB_W-1:0] SYM2_DATA,
  input wire logic LS_STROBE,
  input wire logic [LS_W-1:0] LS_CODE,
  output logic IND_VALID,
  input wire logic IND_READY,
  output logic IND_CTRL,
  output logic [BYTE_W-1:0] IND_DATA,
  output logic [LS_W-1:0] LINE_STATE,
  output logic PHY_INVALID
);

  // ----------------------------------------------------------------------
  // Symbol decoding helpers.
  // ----------------------------------------------------------------------
  function automatic logic is_sym(input logic c, input logic [NIB_W-1:0] d,
                                  input logic [NIB_W-1:0] code);
    return c && (d == code);
  endfunction

  function automatic line_state_t code_to_state(input logic [LS_W-1:0] code);
    line_state_t s;
    s = UNKNOWN_LINE_STATE;
    case (code)
      LSC_ACTIVE: s = ACTIVE_LINE_STATE;
      LSC_IDLE: s = IDLE_LINE_STATE;
      LSC_HALT: s = HALT_LINE_STATE;
      LSC_QUIET: s = QUIET_LINE_STATE;
      LSC_MASTER: s = MASTER_LINE_STATE;
      LSC_NOISE: s = NOISE_LINE_STATE;
      default: s = UNKNOWN_LINE_STATE;
    endcase
    return s;
  endfunction

  function automatic logic [LS_W-1:0] state_to_code(input line_state_t s);
    logic [LS_W-1:0] c;
    c = LSC_UNKNOWN;
    unique case (s)
      ACTIVE_LINE_STATE: c = LSC_ACTIVE;
      IDLE_LINE_STATE: c = LSC_IDLE;
      HALT_LINE_STATE: c = LSC_HALT;
      QUIET_LINE_STATE: c = LSC_QUIET;
      MASTER_LINE_STATE: c = LSC_MASTER;
      NOISE_LINE_STATE: c = LSC_NOISE;
      UNKNOWN_LINE_STATE: c = LSC_UNKNOWN;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // Line state tracking.
  // ----------------------------------------------------------------------
  line_state_t ls_q, ls_d, prev_ls_q, prev_ls_d;
  logic sym_take, jk_pair, both_idle, both_halt, both_quiet, hq_pair;
  logic fifo_in_ready;

  assign sym_take = SYM_VALID && SYM_READY && fifo_in_ready;
  assign jk_pair = is_sym(SYM1_CTRL, SYM1_DATA, SYM_J) && is_sym(SYM2_CTRL, SYM2_DATA, SYM_K);
  assign both_idle = is_sym(SYM1_CTRL, SYM1_DATA, SYM_IDLE)
                     && is_sym(SYM2_CTRL, SYM2_DATA, SYM_IDLE);
  assign both_halt = is_sym(SYM1_CTRL, SYM1_DATA, SYM_HALT)
                     && is_sym(SYM2_CTRL, SYM2_DATA, SYM_HALT);
  assign both_quiet = is_sym(SYM1_CTRL, SYM1_DATA, SYM_QUIET)
                      && is_sym(SYM2_CTRL, SYM2_DATA, SYM_QUIET);
  assign hq_pair = (is_sym(SYM1_CTRL, SYM1_DATA, SYM_HALT)
                    && is_sym(SYM2_CTRL, SYM2_DATA, SYM_QUIET))
                   || (is_sym(SYM1_CTRL, SYM1_DATA, SYM_QUIET)
                    && is_sym(SYM2_CTRL, SYM2_DATA, SYM_HALT));

  always_comb begin
    ls_d = ls_q;
    prev_ls_d = prev_ls_q;
    if (sym_take && jk_pair) begin
      ls_d = ACTIVE_LINE_STATE;
    end else if (LS_STROBE) begin
      ls_d = code_to_state(LS_CODE);
    end
    if (ls_d != ls_q) begin
      prev_ls_d = ls_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ls_q <= QUIET_LINE_STATE;
      prev_ls_q <= QUIET_LINE_STATE;
    end else begin
      ls_q <= ls_d;
      prev_ls_q <= prev_ls_d;
    end
  end

  // ----------------------------------------------------------------------
  // Indicate code encoding.
  // ----------------------------------------------------------------------
  logic phy_inv, match, mixed;
  logic enc_ctrl;
  logic [BYTE_W-1:0] enc_data;

  always_comb begin
    phy_inv = (ls_q == HALT_LINE_STATE) || (ls_q == QUIET_LINE_STATE)
              || (ls_q == MASTER_LINE_STATE) || (ls_q == NOISE_LINE_STATE)
              || ((ls_q == UNKNOWN_LINE_STATE) && ((prev_ls_q == ACTIVE_LINE_STATE)
              || (prev_ls_q == IDLE_LINE_STATE)));
    match = 1'b0;
    unique case (ls_q)
      HALT_LINE_STATE: match = both_halt;
      QUIET_LINE_STATE: match = both_quiet;
      MASTER_LINE_STATE: match = hq_pair;
      IDLE_LINE_STATE: match = both_idle;
      default: match = 1'b0;
    endcase
    mixed = SYM1_CTRL ^ SYM2_CTRL;
    enc_ctrl = 1'b1;
    enc_data = '0;
    unique case (ls_q)
      ACTIVE_LINE_STATE: begin
        enc_ctrl = SYM1_CTRL || SYM2_CTRL;
        enc_data = {(mixed && !SYM1_CTRL) ? ZERO_NIB : SYM1_DATA,
                    (mixed && !SYM2_CTRL) ? ZERO_NIB : SYM2_DATA};
      end
      IDLE_LINE_STATE: begin
        enc_data = {LS_MARK, both_idle ? IDLE_KNOWN_FIELD : IDLE_UNKNOWN_FIELD};
      end
      default: begin
        if (phy_inv && !match) begin
          enc_data = {LS_MARK, PHY_INVALID_FIELD};
        end else begin
          enc_data = {LS_MARK, match, state_to_code(ls_q)};
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Buffering and output registers.
  // ----------------------------------------------------------------------
  logic fifo_out_valid, out_load;
  logic [FIFO_W-1:0] fifo_out_data;
  logic [CNT_W-1:0] fifo_count;
  logic sym_ready_q, sym_ready_d, ind_valid_q, ind_valid_d, ind_ctrl_q, ind_ctrl_d;
  logic phy_inv_q;
  logic [BYTE_W-1:0] ind_data_q, ind_data_d;
  logic [LS_W-1:0] ls_out_q;

  indicate_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .CW(CNT_W)
  ) u_fifo (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .in_valid(SYM_VALID && SYM_READY),
    .in_ready(fifo_in_ready),
    .in_data({enc_ctrl, enc_data}),
    .out_valid(fifo_out_valid),
    .out_ready(out_load),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  assign out_load = !ind_valid_q || IND_READY;

  always_comb begin
    sym_ready_d = (fifo_count <= FIFO_ROOM_LIMIT);
    ind_valid_d = ind_valid_q;
    ind_ctrl_d = ind_ctrl_q;
    ind_data_d = ind_data_q;
    if (out_load) begin
      ind_valid_d = fifo_out_valid;
      if (fifo_out_valid) begin
        ind_ctrl_d = fifo_out_data[BYTE_W];
        ind_data_d = fifo_out_data[BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sym_ready_q <= 1'b0;
      ind_valid_q <= 1'b0;
      ind_ctrl_q <= 1'b0;
      ind_data_q <= '0;
      ls_out_q <= LSC_QUIET;
      phy_inv_q <= 1'b0;
    end else begin
      sym_ready_q <= sym_ready_d;
      ind_valid_q <= ind_valid_d;
      ind_ctrl_q <= ind_ctrl_d;
      ind_data_q <= ind_data_d;
      ls_out_q <= state_to_code(ls_d);
      phy_inv_q <= phy_inv;
    end
  end

  assign SYM_READY = sym_ready_q;
  assign IND_VALID = ind_valid_q;
  assign IND_CTRL = ind_ctrl_q;
  assign IND_DATA = ind_data_q;
  assign LINE_STATE = ls_out_q;
  assign PHY_INVALID = phy_inv_q;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence active_mixed_s;
    sym_take && (ls_q == ACTIVE_LINE_STATE) && mixed;
  endsequence

  sequence jk_take_s;
    sym_take && jk_pair;
  endsequence

  data_pass_a: assert property (
    sym_take && (ls_q == ACTIVE_LINE_STATE) && !SYM1_CTRL && !SYM2_CTRL
    |-> !enc_ctrl && (enc_data == {SYM1_DATA, SYM2_DATA}))
    else $error("Active data pair not forwarded.");

  mixed_zero_a: assert property (
    active_mixed_s |-> enc_ctrl
    && (enc_data[BYTE_W-1:NIB_W] == (SYM1_CTRL ? SYM1_DATA : ZERO_NIB))
    && (enc_data[NIB_W-1:0] == (SYM2_CTRL ? SYM2_DATA : ZERO_NIB)))
    else $error("Mixed pair not zeroed and flagged.");

  jk_active_a: assert property (
    jk_take_s |=> (ls_q == ACTIVE_LINE_STATE) && (LINE_STATE == LSC_ACTIVE))
    else $error("Delimiter did not enter active state.");

  idle_unknown_a: assert property (
    sym_take && (ls_q == IDLE_LINE_STATE) && !both_idle
    |-> enc_ctrl && (enc_data[NIB_W-1:0] == IDLE_UNKNOWN_FIELD))
    else $error("Idle state unknown code wrong.");

  idle_known_a: assert property (
    sym_take && (ls_q == IDLE_LINE_STATE) && both_idle
    |-> enc_ctrl && (enc_data[NIB_W-1:0] == IDLE_KNOWN_FIELD))
    else $error("Idle state known code wrong.");

  known_flag_a: assert property (
    sym_take && (ls_q != ACTIVE_LINE_STATE) && enc_data[KNOWN_BIT] |-> match)
    else $error("Known flag set without matching symbols.");

  other_known_a: assert property (
    sym_take && match && (ls_q != ACTIVE_LINE_STATE) && (ls_q != IDLE_LINE_STATE)
    |-> enc_ctrl && (enc_data[NIB_W-1:0] == {1'b1, state_to_code(ls_q)}))
    else $error("Matching line state code wrong.");

  other_unknown_a: assert property (
    sym_take && !match && phy_inv |-> enc_ctrl && (enc_data[NIB_W-1:0] == PHY_INVALID_FIELD))
    else $error("Invalid condition code wrong.");

  invalid_flag_a: assert property (
    (ls_q == HALT_LINE_STATE) || (ls_q == QUIET_LINE_STATE) |=> PHY_INVALID)
    else $error("Invalid condition not reported.");

  invalid_other_a: assert property (
    (ls_q == MASTER_LINE_STATE) || (ls_q == NOISE_LINE_STATE) |=> PHY_INVALID)
    else $error("Invalid condition not reported in master or noise.");

  invalid_clear_a: assert property (
    (ls_q == ACTIVE_LINE_STATE) || (ls_q == IDLE_LINE_STATE) |=> !PHY_INVALID)
    else $error("Invalid condition reported in active or idle.");

  ready_full_a: assert property (
    !fifo_in_ready |-> !SYM_READY)
    else $error("Symbol input ready while buffer full.");

  out_hold_a: assert property (
    IND_VALID && !IND_READY |=> IND_VALID && $stable(IND_DATA) && $stable(IND_CTRL))
    else $error("Indicate byte changed while stalled.");

endmodule : phy_mac_indicate_encoder

`default_nettype wire

/* File: testbench/mac_sink_model.sv */
// Purpose: Behavioural MAC side that accepts indicate bytes.
// Assumes: Bytes are taken on the rising edge of clk.
// Notes: Mode 0 takes every byte, mode 1 every other cycle, mode 2 stalls.
`default_nettype none

module mac_sink_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] mode,
  input wire logic ind_valid,
  output logic ind_ready,
  input wire logic ind_ctrl,
  input wire logic [7:0] ind_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rx_q[$];
  logic slow_q;
  // Ready only changes on the falling edge.
  always @(negedge clk) begin
    if (!reset_n) begin
      slow_q <= 1'b0;
      ind_ready <= 1'b0;
    end else begin
      slow_q <= ~slow_q;
      ind_ready <= (mode == 2'h0) || (mode == 2'h1 && slow_q);
    end
  end
  // Each accepted byte is kept together with its control flag.
  always @(posedge clk) begin
    if (reset_n && ind_valid && ind_ready) begin
      rx_q.push_back({ind_ctrl, ind_data});
    end
  end
endmodule // mac_sink_model

`default_nettype wire

/* File: testbench/tb_phy_mac_indicate_encoder.sv */
// Purpose: Self-checking bench for the indicate encoder.
// Assumes: Inputs change on the falling edge of CLK.
// Notes: Bytes are collected by the MAC model and compared in order.
`default_nettype none

module tb_phy_mac_indicate_encoder import indicate_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Signals and instances.
  // ----------------------------------------------------------------------
  logic clk, reset_n, sym_valid, sym_ready, s1c, s2c, ls_strobe;
  logic ind_valid, ind_ready, ind_ctrl, phy_invalid;
  logic [NIB_W-1:0] s1d, s2d;
  logic [LS_W-1:0] ls_code, line_state;
  logic [BYTE_W-1:0] ind_data;
  logic [1:0] mode;
  int checks, n_mismatch;

  phy_mac_indicate_encoder u_phy_mac_indicate_encoder (
    .CLK(clk), .RESET_N(reset_n), .SYM_VALID(sym_valid), .SYM_READY(sym_ready),
    .SYM1_CTRL(s1c), .SYM1_DATA(s1d), .SYM2_CTRL(s2c), .SYM2_DATA(s2d),
    .LS_STROBE(ls_strobe), .LS_CODE(ls_code), .IND_VALID(ind_valid),
    .IND_READY(ind_ready), .IND_CTRL(ind_ctrl), .IND_DATA(ind_data),
    .LINE_STATE(line_state), .PHY_INVALID(phy_invalid)
  );

  mac_sink_model u_mac_sink_model (
    .clk(clk), .reset_n(reset_n), .mode(mode), .ind_valid(ind_valid),
    .ind_ready(ind_ready), .ind_ctrl(ind_ctrl), .ind_data(ind_data)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("Counts: checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timeout;
    n_mismatch++;
    $display("Wait limit used up at %0t.", $time);
    final_report;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic c1, input logic [3:0] d1, input logic c2,
                      input logic [3:0] d2);
    int n;
    n = 0;
    s1c = c1;
    s1d = d1;
    s2c = c2;
    s2d = d2;
    if (sym_valid !== 1'b1) sym_valid = 1'b1;
    while (sym_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 100) timeout;
    end
    @(negedge clk);
  endtask

  task automatic expect_byte(input logic [8:0] exp);
    int n;
    n = 0;
    while (u_mac_sink_model.rx_q.size() == 0) begin
      @(negedge clk);
      n++;
      if (n > 100) timeout;
    end
    check(u_mac_sink_model.rx_q.pop_front(), exp);
  endtask

  task automatic set_ls(input logic [LS_W-1:0] code);
    ls_strobe = 1'b1;
    ls_code = code;
    @(negedge clk);
    ls_strobe = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic enter_active;
    send(1'b1, SYM_J, 1'b1, SYM_K);
    sym_valid = 1'b0;
    repeat (6) @(negedge clk);
    u_mac_sink_model.rx_q.delete();
  endtask

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_active;
    enter_active();
    check({6'h00, line_state}, {6'h00, LSC_ACTIVE});
    check({8'h00, phy_invalid}, 9'h000);
    mode = 2'h1;
    send(1'b0, 4'hA, 1'b0, 4'h5);
    send(1'b0, 4'h7, 1'b1, SYM_T);
    send(1'b1, SYM_R, 1'b0, 4'h9);
    send(1'b1, SYM_S, 1'b1, SYM_R);
    sym_valid = 1'b0;
    expect_byte(9'h0A5);
    expect_byte(9'h105);
    expect_byte(9'h160);
    expect_byte(9'h176);
    mode = 2'h0;
    $display("Test active done.");
  endtask

  task automatic t_idle;
    set_ls(LSC_IDLE);
    check({8'h00, phy_invalid}, 9'h000);
    send(1'b1, SYM_IDLE, 1'b1, SYM_IDLE);
    send(1'b1, SYM_IDLE, 1'b1, SYM_HALT);
    send(1'b0, 4'h1, 1'b0, 4'h2);
    sym_valid = 1'b0;
    expect_byte(9'h10B);
    expect_byte(9'h103);
    expect_byte(9'h103);
    $display("Test idle done.");
  endtask

  task automatic t_other;
    logic [2:0] ls_t [7] = '{LSC_HALT, LSC_HALT, LSC_QUIET, LSC_MASTER, LSC_MASTER,
                             LSC_NOISE, LSC_MASTER};
    logic [3:0] a_t [7] = '{SYM_HALT, SYM_IDLE, SYM_QUIET, SYM_HALT, SYM_QUIET,
                            SYM_QUIET, SYM_IDLE};
    logic [3:0] b_t [7] = '{SYM_HALT, SYM_IDLE, SYM_QUIET, SYM_QUIET, SYM_HALT,
                            SYM_QUIET, SYM_IDLE};
    logic [8:0] e_t [7] = '{9'h109, 9'h103, 9'h108, 9'h10A, 9'h10A, 9'h103, 9'h103};
    for (int i = 0; i < 7; i++) begin
      set_ls(ls_t[i]);
      check({8'h00, phy_invalid}, 9'h001);
      send(1'b1, a_t[i], 1'b1, b_t[i]);
      sym_valid = 1'b0;
      expect_byte(e_t[i]);
    end
    set_ls(LSC_IDLE);
    set_ls(LSC_UNKNOWN);
    check({8'h00, phy_invalid}, 9'h001);
    send(1'b1, SYM_QUIET, 1'b1, SYM_QUIET);
    sym_valid = 1'b0;
    expect_byte(9'h103);
    set_ls(LSC_HALT);
    set_ls(LSC_UNKNOWN);
    check({8'h00, phy_invalid}, 9'h000);
    send(1'b1, SYM_HALT, 1'b1, SYM_HALT);
    sym_valid = 1'b0;
    expect_byte(9'h106);
    ls_code = LSC_HALT;
    ls_strobe = 1'b1;
    send(1'b1, SYM_J, 1'b1, SYM_K);
    ls_strobe = 1'b0;
    sym_valid = 1'b0;
    repeat (2) @(negedge clk);
    check({6'h00, line_state}, {6'h00, LSC_ACTIVE});
    expect_byte(9'h106);
    $display("Test other states done.");
  endtask

  task automatic t_fifo;
    int taken;
    logic r;
    enter_active();
    mode = 2'h2;
    taken = 0;
    for (int k = 0; k < 24; k++) begin
      s1c = 1'b0;
      s2c = 1'b0;
      s1d = taken[3:0];
      s2d = ~taken[3:0];
      if (k == 0) sym_valid = 1'b1;
      r = sym_ready;
      @(negedge clk);
      if (r === 1'b1) taken++;
    end
    check({8'h00, sym_ready}, 9'h000);
    check({8'h00, u_mac_sink_model.rx_q.size() == 0}, 9'h001);
    check(9'(taken), 9'(FIFO_DEPTH + 1));
    sym_valid = 1'b0;
    mode = 2'h0;
    for (int k = 0; k < taken; k++) begin
      expect_byte({1'b0, k[3:0], ~k[3:0]});
    end
    $display("Test buffer done.");
  endtask

  initial begin
    reset_n = 1'b0;
    sym_valid = 1'b0;
    s1c = 1'b0;
    s1d = 4'h0;
    s2c = 1'b0;
    s2d = 4'h0;
    ls_strobe = 1'b0;
    ls_code = 3'h0;
    mode = 2'h0;
    checks = 0;
    n_mismatch = 0;
    repeat (20) @(negedge clk);
    check({ind_ctrl, ind_data}, 9'h000);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    check({5'h00, ind_valid, line_state}, {6'h00, LSC_QUIET});
    check({8'h00, phy_invalid}, 9'h001);
    $display("Test reset done.");
    t_active();
    t_idle();
    t_other();
    t_fifo();
    final_report();
  end
endmodule // tb_phy_mac_indicate_encoder

`default_nettype wire
